// [sim/host_proc_interrupt_mask_tb_top.sv]
// Bench joining driver and device ends over the bus interface.
// Assumes clock ready count shortened to a small parameter.
`timescale 1ns/1ns
`default_nettype none
module host_proc_interrupt_mask_tb_top
  import hpim_pkg::*;
;
  localparam int CLKRDY = 10;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [15:0] wd = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [6:0] ev = 7'h00;
  logic ports_susp = 1'b0;
  logic [15:0] rdata;
  logic irq;
  logic susp;
  logic sof_en;
  logic [15:0] v;
  int miscompares = 0;
  int n_compared = 0;
  hpim_if bus();
  always #2 i_clk = ~i_clk;
  hpim_device #(.CLKRDY_CYC(CLKRDY)) i_hpim_device (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .bus(bus), .i_async_list_event(ev[1]), .i_frame_mark(ev[0]), .i_int_xfer_end(ev[2]),
    .i_ext_xfer_end(ev[3]), .i_operational_reg_event(ev[4]), .i_all_ports_suspended(ports_susp),
    .i_wakeup(ev[6]), .o_suspended(susp), .o_sof_enable(sof_en));
  hpim_driver i_hpim_driver (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .bus(bus), .i_addr(addr),
    .i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_irq(irq));
  hpim_assertions i_hpim_assertions (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .cmd_valid(bus.cmd_valid), .cmd_code(bus.cmd_code), .wdata(bus.wdata),
    .rvalid(bus.rvalid), .rdata(bus.rdata), .host_irq_pin(bus.host_irq_pin));
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task sw_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  task sw_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    @(negedge i_clk);
    d = rdata;
  endtask
  // Waits out the driver busy cycle and the one-cycle answer
  task cmd(input logic [7:0] c, input logic [15:0] d);
    sw_wr(HPIM_SW_WDATA, d);
    sw_wr(HPIM_SW_CMD, {8'h00, c});
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
  endtask
  task rd_reg(input logic [7:0] c, output logic [15:0] d);
    cmd(c, 16'h0000);
    sw_rd(HPIM_SW_RDATA, d);
  endtask
  // Held two cycles so the filtered end pin sees both agreeing stages
  task pulse(input int k);
    @(posedge i_clk);
    ev <= 7'h01 << k;
    repeat (2) @(posedge i_clk);
    ev <= 7'h00;
  endtask
  task conclude;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    rd_reg(HPIM_CMD_ENABLE_RD, v);
    chk(v, HPIM_RST_ENABLE);
    rd_reg(HPIM_CMD_STATUS_RD, v);
    chk(v, HPIM_RST_STATUS);
    $display("test reset done");
    // Input 3 is the external end of transfer, landing on bit 2
    for (int k = 0; k < 5; k++) begin
      pulse(k);
      rd_reg(HPIM_CMD_STATUS_RD, v);
      chk(v, 16'h0001 << ((k == 3) ? 2 : k));
      rd_reg(HPIM_CMD_STATUS_RD, v);
      chk(v, 16'h0001 << ((k == 3) ? 2 : k));
      chk({15'h0000, irq}, 16'h0000);
      cmd(HPIM_CMD_STATUS_WR, 16'h0001 << ((k == 3) ? 2 : k));
      rd_reg(HPIM_CMD_STATUS_RD, v);
      chk(v, 16'h0000);
    end
    $display("test events done");
    cmd(HPIM_CMD_ENABLE_WR, 16'hff77);
    rd_reg(HPIM_CMD_ENABLE_RD, v);
    chk(v, 16'h0077);
    pulse(1);
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    chk({15'h0000, irq}, 16'h0000);
    cmd(HPIM_CMD_HWSETUP_WR, 16'h0001);
    chk({15'h0000, irq}, 16'h0001);
    rd_reg(HPIM_CMD_HWSETUP_RD, v);
    chk(v, 16'h0001);
    sw_rd(HPIM_SW_STAT, v);
    chk(v, 16'h0002);
    cmd(8'h3c, 16'h005a);
    sw_rd(HPIM_SW_RDATA, v);
    chk(v, 16'h0001);
    sw_rd(HPIM_SW_WDATA, v);
    chk(v, 16'h005a);
    cmd(HPIM_CMD_ENABLE_WR, 16'h0075);
    chk({15'h0000, irq}, 16'h0000);
    cmd(HPIM_CMD_ENABLE_WR, 16'h0077);
    chk({15'h0000, irq}, 16'h0001);
    cmd(HPIM_CMD_STATUS_WR, 16'h00ff);
    chk({15'h0000, irq}, 16'h0000);
    rd_reg(HPIM_CMD_STATUS_RD, v);
    chk(v, 16'h0000);
    $display("test mask done");
    cmd(HPIM_CMD_ENABLE_WR, 16'h0060);
    @(posedge i_clk);
    ports_susp <= 1'b1;
    cmd(HPIM_CMD_HOSTCTL_WR, 16'h0001);
    chk({14'h0000, susp, sof_en}, 16'h0002);
    pulse(0);
    rd_reg(HPIM_CMD_STATUS_RD, v);
    chk(v, 16'h0020);
    chk({15'h0000, irq}, 16'h0001);
    @(posedge i_clk);
    ports_susp <= 1'b0;
    // Wake first: a host control write would leave suspend with no wake-up
    pulse(6);
    cmd(HPIM_CMD_HOSTCTL_WR, 16'h0000);
    repeat (CLKRDY + 5) @(posedge i_clk);
    @(negedge i_clk);
    chk({14'h0000, susp, sof_en}, 16'h0001);
    rd_reg(HPIM_CMD_STATUS_RD, v);
    chk(v, 16'h0060);
    $display("test suspend done");
    conclude();
  end
endmodule // host_proc_interrupt_mask_tb_top
`default_nettype wire

// [sim/hpim_assertions.sv]
// Bus checker for the host interrupt mask link.
// Assumes one clock; sits beside the interface in the bench top.
`timescale 1ns/1ns
`default_nettype none
module hpim_assertions
  import hpim_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] wdata,
  input wire logic rvalid,
  input wire logic [15:0] rdata,
  input wire logic host_irq_pin
);
  // ----------------------------------------
  // Shadow of mask and global enable
  // ----------------------------------------
  logic [6:0] en_q;
  logic gie_q;
  logic rd_cmd;
  assign rd_cmd = cmd_valid && (cmd_code == HPIM_CMD_STATUS_RD ||
    cmd_code == HPIM_CMD_ENABLE_RD || cmd_code == HPIM_CMD_HWSETUP_RD);
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      en_q <= 7'h00;
      gie_q <= 1'b0;
    end else if (cmd_valid && cmd_code == HPIM_CMD_ENABLE_WR) begin
      en_q <= wdata[6:0] & HPIM_EV_VALID;
    end else if (cmd_valid && cmd_code == HPIM_CMD_HWSETUP_WR) begin
      gie_q <= wdata[HPIM_BIT_GIE];
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  chk_read_answer: assert property (rd_cmd |=> rvalid)
    else $error("read command not answered");
  chk_no_stray: assert property (!rd_cmd |=> !rvalid)
    else $error("answer without read command");
  chk_reserved_zero: assert property (rvalid |-> rdata[15:7] == 9'h000)
    else $error("reserved bits read nonzero");
  chk_idle_data: assert property (!rvalid |-> rdata == 16'h0000)
    else $error("read data outside answer");
  chk_enable_readback: assert property (cmd_valid && cmd_code == HPIM_CMD_ENABLE_RD
    |=> rdata[6:0] == en_q)
    else $error("enable readback wrong");
  chk_mask_all: assert property ((en_q == 7'h00) [*3] |-> !host_irq_pin)
    else $error("pin high with all masked");
  chk_global_off: assert property ((!gie_q) [*3] |-> !host_irq_pin)
    else $error("pin high with global enable off");
  chk_reset_quiet: assert property (disable iff (1'b0) i_sys_rst |=> !host_irq_pin && !rvalid)
    else $error("outputs active in reset");
  cover property (rd_cmd);
  cover property ($rose(host_irq_pin));
  cover property (cmd_valid && cmd_code == HPIM_CMD_HOSTCTL_WR);
  cover property (rvalid && rdata[HPIM_BIT_CLKRDY]);
endmodule // hpim_assertions
`default_nettype wire

// [src/hpim_device.sv]
// Interrupt status, enable and request logic of the host side.
// Assumes event inputs come from same-clock logic, except the external end pin.
// What this block does
// - Async list data ready sets status bit 1
// - Driver reads fill status before async data
// - Frame mark sets status bit 0
// - Driver reads fill status before iso data
// - Enable register read 25h, written A5h
// - Enable bits 6:0 match status bits
// - Pin needs status, enable and global enable
// - Enable bits reset to zero
// - Writing one unmasks the event
// - Enable bit 6 gates clock ready
// - Bit 5 gates suspend; suspend stops frames
// - Driver suspends via host control write
// - Enable bit 4 gates operational register event
// - Enable bit 2 gates end of transfer
// - Enable bit 1 gates async list event
// - Driver accesses DMA setup before iso DMA
// - Status cleared only by writing one
// - Internal or external end sets bit 2
// - Clock ready within 1 ms of wake-up
`timescale 1ns/1ns
`default_nettype none
module hpim_device
  import hpim_pkg::*;
#(
  parameter int CLKRDY_CYC = HPIM_CLKRDY_CYC
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  hpim_if.device bus,
  input wire logic i_async_list_event,
  input wire logic i_frame_mark,
  input wire logic i_int_xfer_end,
  input wire logic i_ext_xfer_end,
  input wire logic i_operational_reg_event,
  input wire logic i_all_ports_suspended,
  input wire logic i_wakeup,
  output logic o_suspended,
  output logic o_sof_enable
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [6:0] status_q, status_d;
  logic [6:0] enable_q, enable_d;
  logic gie_q, gie_d;
  logic susp_req_q, susp_req_d;
  logic susp_q, susp_d;
  logic wake_q, wake_d;
  logic [HPIM_CNT_W-1:0] cnt_q, cnt_d;
  logic rvalid_q, rvalid_d;
  logic [15:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic [6:0] set_ev;
  logic wr_status, wr_enable, wr_hw, wr_hctl;
  logic clk_ready;
  logic [2:0] xend_sync_q, xend_sync_d;
  logic xend_lvl_q, xend_lvl_d;
  logic xend_rise;

  function automatic logic hit(input logic [7:0] code, input logic [7:0] want);
    hit = code == want;
  endfunction

  // ----------------------------------------
  // External end-of-transfer filter
  // ----------------------------------------
  // Edge counts only once the last two stages agree, so glitches drop out
  always_comb begin
    xend_sync_d = {xend_sync_q[1:0], i_ext_xfer_end};
    xend_lvl_d = xend_lvl_q;
    xend_rise = 1'b0;
    if (xend_sync_q[2] == xend_sync_q[1]) begin
      xend_lvl_d = xend_sync_q[2];
      xend_rise = xend_sync_q[2] && !xend_lvl_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      xend_sync_q <= '0;
      xend_lvl_q <= 1'b0;
    end else begin
      xend_sync_q <= xend_sync_d;
      xend_lvl_q <= xend_lvl_d;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    wr_status = bus.cmd_valid && hit(bus.cmd_code, HPIM_CMD_STATUS_WR);
    wr_enable = bus.cmd_valid && hit(bus.cmd_code, HPIM_CMD_ENABLE_WR);
    wr_hw = bus.cmd_valid && hit(bus.cmd_code, HPIM_CMD_HWSETUP_WR);
    wr_hctl = bus.cmd_valid && hit(bus.cmd_code, HPIM_CMD_HOSTCTL_WR);
    clk_ready = wake_q && (cnt_q == HPIM_CNT_W'(CLKRDY_CYC - 1));
    set_ev = '0;
    set_ev[HPIM_BIT_ASYNC] = i_async_list_event;
    set_ev[HPIM_BIT_FRAME] = i_frame_mark && !susp_q;
    set_ev[HPIM_BIT_XFER_END] = i_int_xfer_end || xend_rise;
    set_ev[HPIM_BIT_OPREG] = i_operational_reg_event;
    set_ev[HPIM_BIT_SUSP] = !susp_q && susp_req_q && i_all_ports_suspended;
    set_ev[HPIM_BIT_CLKRDY] = clk_ready;
    // Set wins over a clear in the same cycle
    status_d = status_q;
    if (wr_status) begin
      status_d = status_q & ~bus.wdata[6:0];
    end
    status_d = (status_d | set_ev) & HPIM_EV_VALID;
    enable_d = enable_q;
    if (wr_enable) begin
      enable_d = bus.wdata[6:0] & HPIM_EV_VALID;
    end
    gie_d = wr_hw ? bus.wdata[HPIM_BIT_GIE] : gie_q;
    susp_req_d = wr_hctl ? bus.wdata[HPIM_BIT_SUSP_REQ] : susp_req_q;
    susp_d = susp_q;
    if (set_ev[HPIM_BIT_SUSP]) begin
      susp_d = 1'b1;
    end else if (i_wakeup || (wr_hctl && !bus.wdata[HPIM_BIT_SUSP_REQ])) begin
      susp_d = 1'b0;
    end
    wake_d = wake_q;
    cnt_d = cnt_q;
    if (i_wakeup && susp_q) begin
      wake_d = 1'b1;
      cnt_d = '0;
    end else if (clk_ready) begin
      wake_d = 1'b0;
    end else if (wake_q) begin
      cnt_d = cnt_q + 1'b1;
    end
    // Uses next values so the pin changes in the same cycle as status, with no lag
    irq_d = gie_d && |(status_d & enable_d);
  end

  // ----------------------------------------
  // Read answer
  // ----------------------------------------
  always_comb begin
    rvalid_d = 1'b0;
    rdata_d = '0;
    if (bus.cmd_valid) begin
      case (bus.cmd_code)
        HPIM_CMD_STATUS_RD: begin
          rvalid_d = 1'b1;
          rdata_d = {9'h000, status_q};
        end
        HPIM_CMD_ENABLE_RD: begin
          rvalid_d = 1'b1;
          rdata_d = {9'h000, enable_q};
        end
        HPIM_CMD_HWSETUP_RD: begin
          rvalid_d = 1'b1;
          rdata_d = {15'h0000, gie_q};
        end
        default: begin
          rvalid_d = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      status_q <= HPIM_RST_STATUS[6:0];
      enable_q <= HPIM_RST_ENABLE[6:0];
      gie_q <= HPIM_RST_HWSETUP[HPIM_BIT_GIE];
      susp_req_q <= 1'b0;
      susp_q <= 1'b0;
      wake_q <= 1'b0;
      cnt_q <= '0;
      irq_q <= 1'b0;
      o_suspended <= 1'b0;
      o_sof_enable <= 1'b1;
    end else begin
      status_q <= status_d;
      enable_q <= enable_d;
      gie_q <= gie_d;
      susp_req_q <= susp_req_d;
      susp_q <= susp_d;
      wake_q <= wake_d;
      cnt_q <= cnt_d;
      irq_q <= irq_d;
      o_suspended <= susp_d;
      o_sof_enable <= !susp_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
    end
  end

  assign bus.rvalid = rvalid_q;
  assign bus.rdata = rdata_q;
  assign bus.host_irq_pin = irq_q;
endmodule // hpim_device
`default_nettype wire

// [src/hpim_driver.sv]
// Host-driver end: turns software port writes into bus commands.
// Assumes the device answers reads exactly one cycle after the command.
`timescale 1ns/1ns
`default_nettype none
module hpim_driver
  import hpim_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  hpim_if.driver bus,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic o_irq
);
  // ----------------------------------------
  // Command issue and read capture
  // ----------------------------------------
  hpim_state_e st_q, st_d;
  logic [15:0] wbuf_q, wbuf_d;
  logic [15:0] last_q, last_d;
  logic cv_q, cv_d;
  logic [7:0] code_q, code_d;
  logic [15:0] bw_q, bw_d;
  logic [15:0] rd_q, rd_d;
  logic irq_q;

  always_comb begin
    st_d = st_q;
    wbuf_d = wbuf_q;
    last_d = last_q;
    cv_d = 1'b0;
    code_d = code_q;
    bw_d = bw_q;
    rd_d = '0;
    if (bus.rvalid) begin
      last_d = bus.rdata;
    end
    case (st_q)
      HPIM_IDLE: begin
        // Write-command codes go out with the buffered data; left to software
        if (i_wr && i_addr == HPIM_SW_WDATA) begin
          wbuf_d = i_wdata;
        end else if (i_wr && i_addr == HPIM_SW_CMD) begin
          cv_d = 1'b1;
          code_d = i_wdata[7:0];
          bw_d = wbuf_q;
          st_d = HPIM_WAIT;
        end
      end
      HPIM_WAIT: begin
        st_d = HPIM_IDLE;
      end
      default: begin
        st_d = HPIM_IDLE;
      end
    endcase
    if (i_rd) begin
      case (i_addr)
        HPIM_SW_RDATA: rd_d = last_q;
        HPIM_SW_STAT: rd_d = {14'h0000, bus.host_irq_pin, st_q == HPIM_WAIT};
        HPIM_SW_WDATA: rd_d = wbuf_q;
        default: rd_d = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_q <= HPIM_IDLE;
      wbuf_q <= '0;
      last_q <= '0;
      cv_q <= 1'b0;
      code_q <= '0;
      bw_q <= '0;
      rd_q <= '0;
      irq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      wbuf_q <= wbuf_d;
      last_q <= last_d;
      cv_q <= cv_d;
      code_q <= code_d;
      bw_q <= bw_d;
      rd_q <= rd_d;
      irq_q <= bus.host_irq_pin;
    end
  end

  assign bus.cmd_valid = cv_q;
  assign bus.cmd_code = code_q;
  assign bus.wdata = bw_q;
  assign o_rdata = rd_q;
  assign o_irq = irq_q;
endmodule // hpim_driver
`default_nettype wire

// [src/hpim_if.sv]
// Processor bus between host driver and interrupt block.
// Assumes both ends share i_clk; the bench drives the clock.
`timescale 1ns/1ns
`default_nettype none
interface hpim_if;
  logic cmd_valid;
  logic [7:0] cmd_code;
  logic [15:0] wdata;
  logic rvalid;
  logic [15:0] rdata;
  logic host_irq_pin;
  modport device (input cmd_valid, input cmd_code, input wdata,
                  output rvalid, output rdata, output host_irq_pin);
  modport driver (output cmd_valid, output cmd_code, output wdata,
                  input rvalid, input rdata, input host_irq_pin);
endinterface
`default_nettype wire

// [src/hpim_pkg.sv]
// Constants shared by both ends of the host interrupt mask link.
// Assumes a single 250 MHz system clock on both ends.
`default_nettype none
package hpim_pkg;
  // ----------------------------------------
  // Command codes on the processor bus
  // ----------------------------------------
  localparam logic [7:0] HPIM_CMD_STATUS_RD = 8'h24;
  localparam logic [7:0] HPIM_CMD_STATUS_WR = 8'ha4;
  localparam logic [7:0] HPIM_CMD_ENABLE_RD = 8'h25;
  localparam logic [7:0] HPIM_CMD_ENABLE_WR = 8'ha5;
  localparam logic [7:0] HPIM_CMD_HWSETUP_RD = 8'h20;
  localparam logic [7:0] HPIM_CMD_HWSETUP_WR = 8'ha0;
  localparam logic [7:0] HPIM_CMD_HOSTCTL_WR = 8'h81;
  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int HPIM_W = 16;
  localparam int HPIM_EV_W = 7;
  localparam int HPIM_BIT_FRAME = 0;
  localparam int HPIM_BIT_ASYNC = 1;
  localparam int HPIM_BIT_XFER_END = 2;
  localparam int HPIM_BIT_OPREG = 4;
  localparam int HPIM_BIT_SUSP = 5;
  localparam int HPIM_BIT_CLKRDY = 6;
  localparam int HPIM_BIT_GIE = 0;
  localparam int HPIM_BIT_SUSP_REQ = 0;
  localparam logic [6:0] HPIM_EV_VALID = 7'h77;
  localparam logic [15:0] HPIM_RST_ENABLE = 16'h0000;
  localparam logic [15:0] HPIM_RST_STATUS = 16'h0000;
  localparam logic [15:0] HPIM_RST_HWSETUP = 16'h0000;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int HPIM_CLK_MHZ = 250;
  localparam int HPIM_CLKRDY_MAX_US = 1000;
  localparam int HPIM_CLKRDY_CYC = HPIM_CLKRDY_MAX_US * HPIM_CLK_MHZ;
  localparam int HPIM_CNT_W = 18;
  // ----------------------------------------
  // Controller software port offsets
  // ----------------------------------------
  localparam logic [3:0] HPIM_SW_CMD = 4'h0;
  localparam logic [3:0] HPIM_SW_WDATA = 4'h1;
  localparam logic [3:0] HPIM_SW_RDATA = 4'h2;
  localparam logic [3:0] HPIM_SW_STAT = 4'h3;
  typedef enum {HPIM_IDLE, HPIM_WAIT} hpim_state_e;
endpackage
`default_nettype wire
